// [rtl/atm_top.sv]
// atm_top: threshold trigger, amplifier and value monitor with registers
//
// The address map and the Avalon-MM register port were decided locally.
module atm_top (
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire atm_pkg::atm_avs_req_t i_avs,
    output logic [31:0]               o_avs_readdata,
    output logic                      o_avs_waitrequest,
    input  wire atm_pkg::atm_val_t    i_analog_in,
    input  wire atm_pkg::atm_val_t    i_live_set,
    input  wire atm_pkg::atm_val_t    i_live_clr,
    input  wire logic                 i_arm,
    input  wire logic                 i_scan,
    output logic                      o_trig_q,
    output logic                      o_mon_q,
    output atm_pkg::atm_val_t         o_analog_out
);
    import atm_pkg::*;

    //************************************************************
    // declarations
    //************************************************************
    atm_state_t         st_r;
    atm_state_t         st_nxt;
    atm_val_t           scaled;
    atm_val_t           set_val;
    atm_val_t           clr_val;
    atm_val_t           ref_now;
    logic signed [17:0] band_abs;
    logic signed [17:0] band_lo;
    logic signed [17:0] band_hi;
    logic signed [39:0] wd40;
    logic signed [39:0] raw40;
    logic [31:0]        rd_mux;
    logic               req;
    logic               rise;
    logic               in_band;
    logic               in_win;

    //************************************************************
    // scaling stage
    //************************************************************
    // one stage serves all three functions; the input word is taken
    // as is, codes 0..FULL_CODE standing for 0..FULL_VOLT volts
    atm_scale #(
        .DIV      (GAIN_DIV)
    ) u_scale (
        .i_value  (i_analog_in),
        .i_gain   (st_r.gain),
        .i_ofs    (st_r.ofs),
        .o_scaled (scaled)
    );

    //************************************************************
    // operand selection and comparisons
    //************************************************************
    // thresholds come from a register or another block's live value
    assign set_val = st_r.set_live ? i_live_set : st_r.set_thr;
    assign clr_val = st_r.clr_live ? i_live_clr : st_r.clr_thr;

    // window test for on < off; plain integer compare, no decimals
    assign in_win = (scaled >= set_val) && (scaled < clr_val);

    // a rising arm compares against the value captured this scan
    assign rise    = i_arm & ~st_r.arm_prev;
    assign ref_now = rise ? scaled : st_r.ref_val;

    // a negative band is folded to its magnitude so it never inverts
    assign band_abs = (st_r.band < 0) ? -18'(st_r.band)
                                      : 18'(st_r.band);
    assign band_lo  = 18'(ref_now) - band_abs;
    assign band_hi  = 18'(ref_now) + band_abs;
    assign in_band  = (18'(scaled) >= band_lo) &&
                      (18'(scaled) <= band_hi);

    //************************************************************
    // register bus helpers
    //************************************************************
    assign req  = i_avs.read | i_avs.write;
    assign wd40 = 40'(signed'(i_avs.writedata[15:0]));

    // read data, narrow fields zero-extended, holes read as zero
    always_comb begin
        rd_mux = '0;
        unique case (i_avs.address)
            OFS_GAIN:    rd_mux[15:0] = st_r.gain;
            OFS_OFFSET:  rd_mux[15:0] = st_r.ofs;
            OFS_SET_THR: rd_mux[15:0] = st_r.set_thr;
            OFS_CLR_THR: rd_mux[15:0] = st_r.clr_thr;
            OFS_BAND:    rd_mux[15:0] = st_r.band;
            OFS_CTRL: begin
                rd_mux[CTRL_SET_LIVE]            = st_r.set_live;
                rd_mux[CTRL_CLR_LIVE]            = st_r.clr_live;
                rd_mux[CTRL_DEC_LSB+:2]          = st_r.dec;
            end
            OFS_STATUS: begin
                rd_mux[ST_TRIG]                  = st_r.trig_q;
                rd_mux[ST_MON]                   = st_r.mon_q;
                rd_mux[ST_OUT_LSB+:16]           = st_r.aout;
            end
            OFS_REF:     rd_mux[15:0] = st_r.ref_val;
            default:     rd_mux = '0;
        endcase
    end

    //************************************************************
    // next state
    //************************************************************
    always_comb begin
        st_nxt = st_r;

        // bus: take a request in idle, answer with one low cycle
        unique case (st_r.bus_st)
            BUS_IDLE: begin
                if (req) begin
                    st_nxt.bus_st  = BUS_ACK;
                    st_nxt.waitreq = 1'b0;
                    st_nxt.rdata   = i_avs.read ? rd_mux : '0;
                end
            end
            BUS_ACK: begin
                st_nxt.bus_st  = BUS_IDLE;
                st_nxt.waitreq = 1'b1;
                // write lands on the edge that sees waitrequest low
                if (i_avs.write) begin
                    unique case (i_avs.address)
                        OFS_GAIN:
                            st_nxt.gain = atm_clamp(wd40, -GAIN_LIM,
                                                    GAIN_LIM);
                        OFS_OFFSET:
                            st_nxt.ofs = atm_clamp(wd40, -OFS_LIM,
                                                   OFS_LIM);
                        OFS_SET_THR:
                            st_nxt.set_thr = atm_clamp(wd40, -THR_LIM,
                                                       THR_LIM);
                        OFS_CLR_THR:
                            st_nxt.clr_thr = atm_clamp(wd40, -THR_LIM,
                                                       THR_LIM);
                        OFS_BAND:
                            st_nxt.band = atm_clamp(wd40, -BAND_LIM,
                                                    BAND_LIM);
                        OFS_CTRL: begin
                            st_nxt.set_live =
                                i_avs.writedata[CTRL_SET_LIVE];
                            st_nxt.clr_live =
                                i_avs.writedata[CTRL_CLR_LIVE];
                            // kept for display only, never compared
                            st_nxt.dec =
                                i_avs.writedata[CTRL_DEC_LSB+:2];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase

        // functions advance only on a scan pulse
        if (i_scan) begin
            st_nxt.aout     = scaled;
            st_nxt.arm_prev = i_arm;
            if (set_val >= clr_val) begin
                // hysteresis: between thresholds the output holds
                if (scaled > set_val)
                    st_nxt.trig_q = 1'b1;
                else if (scaled <= clr_val)
                    st_nxt.trig_q = 1'b0;
            end else begin
                st_nxt.trig_q = in_win;
            end
            if (rise)
                st_nxt.ref_val = scaled;
            // disarm or inside band both clear the monitor
            st_nxt.mon_q = i_arm & ~in_band;
        end
    end

    //************************************************************
    // state register
    //************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // outputs straight from the state flip-flops
    assign o_avs_readdata    = st_r.rdata;
    assign o_avs_waitrequest = st_r.waitreq;
    assign o_trig_q          = st_r.trig_q;
    assign o_mon_q           = st_r.mon_q;
    assign o_analog_out      = st_r.aout;

    //************************************************************
    // assertions
    //************************************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_hyst_mode;
        i_scan && (set_val >= clr_val);
    endsequence

    sequence s_bus_take;
        req && o_avs_waitrequest;
    endsequence

    sequence s_bus_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    sequence s_thr_write;
        i_avs.write && !o_avs_waitrequest &&
        (i_avs.address == OFS_SET_THR);
    endsequence

    sequence s_arm_edge;
        i_scan && rise;
    endsequence

    a_trig_sets: assert property (
        s_hyst_mode and (scaled > set_val) |=> o_trig_q
    ) else $error("trigger did not set above on threshold");

    a_trig_clears: assert property (
        s_hyst_mode and (scaled <= clr_val) and (scaled <= set_val)
        |=> !o_trig_q
    ) else $error("trigger did not clear at off threshold");

    a_trig_holds: assert property (
        s_hyst_mode and (scaled <= set_val) and (scaled > clr_val)
        |=> $stable(o_trig_q)
    ) else $error("trigger changed between thresholds");

    a_trig_window: assert property (
        i_scan && (set_val < clr_val)
        |=> o_trig_q == $past(in_win)
    ) else $error("window trigger output wrong");

    a_amp_output: assert property (
        i_scan |=> (o_analog_out == $past(scaled)) &&
                   (o_analog_out <= OUT_MAX)
    ) else $error("amplifier output not scaled value");

    a_ref_capture: assert property (
        s_arm_edge |=> st_r.ref_val == $past(scaled)
    ) else $error("reference not captured on arm edge");

    a_mon_outside: assert property (
        i_scan && i_arm && !in_band |=> o_mon_q
    ) else $error("monitor not set outside band");

    a_mon_inside: assert property (
        (i_scan && (in_band || !i_arm)) |=> !o_mon_q
    ) else $error("monitor not cleared");

    a_band_range: assert property (
        (st_r.band <= BAND_LIM) && (st_r.band >= -BAND_LIM)
    ) else $error("band width outside range");

    a_gain_range: assert property (
        (st_r.gain <= GAIN_LIM) && (st_r.gain >= -GAIN_LIM)
    ) else $error("gain outside range");

    a_thr_write: assert property (
        s_thr_write |=> st_r.set_thr ==
            atm_clamp($past(wd40), -THR_LIM, THR_LIM)
    ) else $error("set threshold write lost");

    a_scan_hold: assert property (
        !i_scan |=> $stable(o_trig_q) && $stable(o_mon_q) &&
                    $stable(o_analog_out)
    ) else $error("outputs changed without scan");

    a_bus_answer: assert property (
        s_bus_take |=> s_bus_answer
    ) else $error("bus answer not one low cycle");

    // wide scaling kept apart from the stage, so the checks below do
    // not lean on the clamp that they are meant to watch
    assign raw40 = 40'(i_analog_in) * 40'(st_r.gain) / 40'(GAIN_DIV)
                   + 40'(st_r.ofs);

    sequence s_gain_read;
        i_avs.read && o_avs_waitrequest && (i_avs.address == OFS_GAIN);
    endsequence

    sequence s_ctrl_write;
        i_avs.write && !o_avs_waitrequest && !i_scan &&
        (i_avs.address == OFS_CTRL);
    endsequence

    a_gain_read: assert property (
        s_gain_read |=> o_avs_readdata == {16'h0000, $past(st_r.gain)}
    ) else $error("gain readback wrong");

    // decimals are display only: a control write leaves compares alone
    a_dec_ignored: assert property (
        s_ctrl_write |=> $stable(st_r.set_thr) && $stable(st_r.clr_thr) &&
                         $stable(o_trig_q)
    ) else $error("decimals write moved a threshold or output");

    // live operands are checked apart from the register path
    a_live_window: assert property (
        i_scan && st_r.set_live && st_r.clr_live &&
        (i_live_set < i_live_clr)
        |=> o_trig_q == (($past(scaled) >= $past(i_live_set)) &&
                         ($past(scaled) < $past(i_live_clr)))
    ) else $error("live thresholds not used");

    // a wrapped word would flip its sign; the clip must hold instead
    a_clip_high: assert property (
        i_scan && (raw40 > 40'(OUT_MAX)) |=> o_analog_out == OUT_MAX
    ) else $error("amplifier did not saturate high");

    a_clip_low: assert property (
        i_scan && (raw40 < 40'(OUT_MIN)) |=> o_analog_out == OUT_MIN
    ) else $error("amplifier did not saturate low");

    // inside the word range the output is exactly input*gain/GAIN_DIV+offset
    a_amp_linear: assert property (
        i_scan && (raw40 <= 40'(OUT_MAX)) && (raw40 >= 40'(OUT_MIN))
        |=> 40'(o_analog_out) == $past(raw40)
    ) else $error("amplifier output not gain times input plus offset");

    a_ref_hold: assert property (
        i_scan && !rise |=> $stable(st_r.ref_val)
    ) else $error("reference moved without arm edge");

    // both sides scaled alike: a fresh reference sits inside its band
    a_arm_inside: assert property (
        s_arm_edge |=> !o_mon_q
    ) else $error("fresh reference not inside its own band");

    a_ofs_range: assert property (
        (st_r.ofs <= OFS_LIM) && (st_r.ofs >= -OFS_LIM)
    ) else $error("offset outside range");

    a_thr_range: assert property (
        (st_r.set_thr <= THR_LIM) && (st_r.set_thr >= -THR_LIM) &&
        (st_r.clr_thr <= THR_LIM) && (st_r.clr_thr >= -THR_LIM)
    ) else $error("threshold outside range");

endmodule : atm_top

// [shared/atm_pkg.sv]
// atm_pkg: constants, types and helpers of the analog threshold monitor
//
// How it works
// - trigger value is input times gain plus offset
// - on>=off: set above on, clear at/below off
// - on<off: output high inside [on, off)
// - input codes 0..1000 span zero to ten volts
// - gain, offset and thresholds clamped to ranges
// - decimals setting never alters comparisons
// - each threshold is constant or live value
// - amplifier output scaled, limited to 16 bits
// - arm rising edge captures the reference
// - reference and live input scaled alike
// - monitor high when armed and outside band
// - monitor low inside band or when disarmed
// - band width clamped to plus/minus 20000
// - thresholds and decimals writable at run time
package atm_pkg;

    //************************************************************
    // scaling and ranges
    //************************************************************
    localparam int FULL_VOLT = 10;        // input span in volts
    localparam int FULL_CODE = 1000;      // code at FULL_VOLT
    localparam int GAIN_DIV  = 100;       // gain carries hundredths
    localparam int GAIN_LIM  = 1000;      // +/-10.00
    localparam int OFS_LIM   = 10000;
    localparam int THR_LIM   = 20000;
    localparam int BAND_LIM  = 20000;
    localparam int OUT_MAX   = 32767;
    localparam int OUT_MIN   = -32768;

    //************************************************************
    // register map (byte addresses)
    //************************************************************
    localparam int           ADDR_W      = 5;
    localparam logic [4:0]   OFS_GAIN    = 5'h00;
    localparam logic [4:0]   OFS_OFFSET  = 5'h04;
    localparam logic [4:0]   OFS_SET_THR = 5'h08;
    localparam logic [4:0]   OFS_CLR_THR = 5'h0C;
    localparam logic [4:0]   OFS_BAND    = 5'h10;
    localparam logic [4:0]   OFS_CTRL    = 5'h14;
    localparam logic [4:0]   OFS_STATUS  = 5'h18;
    localparam logic [4:0]   OFS_REF     = 5'h1C;
    localparam int           CTRL_SET_LIVE = 0;
    localparam int           CTRL_CLR_LIVE = 1;
    localparam int           CTRL_DEC_LSB  = 2;
    localparam int           ST_TRIG       = 0;
    localparam int           ST_MON        = 1;
    localparam int           ST_OUT_LSB    = 16;
    localparam logic [15:0]  RST_GAIN      = 16'h0064; // gain 1.00

    //************************************************************
    // types
    //************************************************************
    typedef logic signed [15:0] atm_val_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } atm_bus_st_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } atm_avs_req_t;

    typedef struct packed {
        atm_bus_st_t bus_st;
        logic        waitreq;
        logic [31:0] rdata;
        atm_val_t    gain;
        atm_val_t    ofs;
        atm_val_t    set_thr;
        atm_val_t    clr_thr;
        atm_val_t    band;
        logic        set_live;
        logic        clr_live;
        logic [1:0]  dec;
        logic        arm_prev;
        atm_val_t    ref_val;
        logic        trig_q;
        logic        mon_q;
        atm_val_t    aout;
    } atm_state_t;

    localparam atm_state_t ST_RST = '{
        bus_st  : BUS_IDLE,
        waitreq : 1'b1,
        gain    : atm_val_t'(RST_GAIN),
        default : '0
    };

    // saturate a wide signed value into a 16-bit word
    function automatic atm_val_t atm_clamp(
        input logic signed [39:0] v,
        input int                 lo,
        input int                 hi
    );
        if (v > 40'(signed'(hi)))
            return atm_val_t'(hi[15:0]);
        if (v < 40'(signed'(lo)))
            return atm_val_t'(lo[15:0]);
        return atm_val_t'(v[15:0]);
    endfunction : atm_clamp

endpackage : atm_pkg

// [rtl/atm_scale.sv]
// atm_scale: shared gain and offset stage with saturation
module atm_scale #(
    parameter int DIV = atm_pkg::GAIN_DIV
) (
    input  wire atm_pkg::atm_val_t i_value,
    input  wire atm_pkg::atm_val_t i_gain,
    input  wire atm_pkg::atm_val_t i_ofs,
    output atm_pkg::atm_val_t      o_scaled
);
    import atm_pkg::*;

    //************************************************************
    // arithmetic
    //************************************************************
    localparam logic signed [39:0] DIV_W = 40'(DIV);

    logic signed [39:0] prod;
    logic signed [39:0] quot;
    logic signed [39:0] sum;

    generate
        if (DIV < 1) begin : g_bad_div
            $error("atm_scale: DIV must be at least one");
        end
    endgenerate

    // 40 bits hold 16x16 product plus offset without overflow
    assign prod = 40'(i_value) * 40'(i_gain);
    assign quot = prod / DIV_W;                   // truncates to zero
    assign sum  = quot + 40'(i_ofs);
    // clip instead of wrap at the 16-bit word limits
    assign o_scaled = atm_clamp(sum, OUT_MIN, OUT_MAX);

endmodule : atm_scale

// [verif/atm_src_model.sv]
// atm_src_model: upstream analog source and scan pacer for the monitor block
module atm_src_model (
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_go,
    input  wire atm_pkg::atm_val_t i_ain,
    input  wire atm_pkg::atm_val_t i_ls,
    input  wire atm_pkg::atm_val_t i_lc,
    output atm_pkg::atm_val_t      o_analog_in,
    output atm_pkg::atm_val_t      o_live_set,
    output atm_pkg::atm_val_t      o_live_clr,
    output logic                   o_scan
);
    timeunit 1ns;
    timeprecision 1ns;
    import atm_pkg::*;

    // words change only with a scan request, so each scan sees a fresh,
    // settled word; between scans they hold like a converter latch
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_scan      <= 1'b0;
            o_analog_in <= '0;
            o_live_set  <= '0;
            o_live_clr  <= '0;
        end else begin
            o_scan <= i_go;               // one-cycle scan pulse
            if (i_go) begin
                o_analog_in <= i_ain;     // converter code word
                o_live_set  <= i_ls;      // other block's value
                o_live_clr  <= i_lc;      // other block's value
            end
        end
    end

endmodule : atm_src_model

// [verif/tb_top.sv]
// tb_top: self-checking bench for the analog threshold monitor
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import atm_pkg::*;

    typedef struct {
        int g, o, s, c, k, ls, lc, a, x;
    } atm_row_t;

    localparam int NROW = 21;
    localparam int BAND = 50;

    logic         i_clk;
    logic         i_sys_rst;
    logic         i_arm;
    logic         go;
    atm_avs_req_t avs;
    atm_val_t     ain_d, ls_d, lc_d, ain, ls, lc, aout;
    logic         scan, trig_q, mon_q, waitreq;
    logic [31:0]  rdata;
    int           err_total, n_checks, v, sv, cv, eref, dly_n;
    logic         et, em, aprev;
    atm_row_t     r;

    // gain, offset, set, clear, ctrl, live set, live clear, arm, input
    atm_row_t rows [NROW] = '{
        '{100, 0, 500, 200, 0, 0, 0, 0, 600}, '{100, 0, 500, 200, 0, 0, 0, 0, 300},
        '{100, 0, 500, 200, 0, 0, 0, 0, 200}, '{100, 0, 500, 200, 0, 0, 0, 0, 500},
        '{100, 0, 100, 400, 0, 0, 0, 0, 100}, '{100, 0, 100, 400, 0, 0, 0, 0, 400},
        '{100, 0, 100, 400, 12, 0, 0, 0, 399}, '{-1000, 10000, 100, 400, 0, 0, 0, 0, 1000},
        '{1000, 10000, 20000, -20000, 0, 0, 0, 0, 30000},
        '{-1000, 0, 20000, -20000, 0, 0, 0, 0, 30000},
        '{10, -30, 15, 5, 0, 0, 0, 0, 455}, '{33, 0, 0, 0, 0, 0, 0, 0, -7},
        '{100, 0, 0, 0, 3, 300, 100, 0, 350}, '{100, 0, 0, 0, 3, 100, 300, 0, 300},
        '{100, 0, 500, 200, 0, 0, 0, 1, 300}, '{100, 0, 500, 200, 0, 0, 0, 1, 351},
        '{100, 0, 500, 200, 0, 0, 0, 1, 350}, '{100, 0, 500, 200, 0, 0, 0, 1, 249},
        '{100, 0, 500, 200, 0, 0, 0, 0, 249}, '{200, 0, 500, 200, 0, 0, 0, 1, 100},
        '{200, 0, 500, 200, 0, 0, 0, 1, 126}
    };

    //************************************************************
    // clock, design and upstream model
    //************************************************************
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    atm_top u_atm_top (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs(avs),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_analog_in(ain), .i_live_set(ls), .i_live_clr(lc), .i_arm(i_arm),
        .i_scan(scan), .o_trig_q(trig_q), .o_mon_q(mon_q), .o_analog_out(aout)
    );

    atm_src_model u_atm_src_model (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go), .i_ain(ain_d),
        .i_ls(ls_d), .i_lc(lc_d), .o_analog_in(ain), .o_live_set(ls),
        .o_live_clr(lc), .o_scan(scan)
    );

    // on-delay count behind the trigger: cycles that trig_q has stayed high
    always @(posedge i_clk) dly_n <= trig_q ? dly_n + 1 : 0;

    //************************************************************
    // shared tasks
    //************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // avalon master: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr_n, input logic [4:0] a, input int d,
                       output logic [31:0] q);
        @(posedge i_clk);
        avs <= '{read: !wr_n, write: wr_n, address: a, writedata: d};
        // only the watchdog ends a wait that never sees the answer
        do begin
            @(posedge i_clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        avs <= '0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input int d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 0, q);
        check(q, e);
    endtask : rd_chk

    // outputs are visible two edges after the request edge
    task automatic scan_in(input int a, input int s, input int c, input int arm);
        @(posedge i_clk);
        ain_d <= 16'(a);
        ls_d  <= 16'(s);
        lc_d  <= 16'(c);
        i_arm <= arm[0];
        go    <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : scan_in

    // reference scaling: truncate toward zero, then saturate
    function automatic int scl(input int x, input int g, input int o);
        int t;
        t = (x * g) / GAIN_DIV + o;
        return (t > OUT_MAX) ? OUT_MAX : ((t < OUT_MIN) ? OUT_MIN : t);
    endfunction : scl

    task automatic chk_rst();
        check(trig_q, 1'b0);
        check(mon_q, 1'b0);
        check(32'(aout), 32'h00000000);
        rd_chk(OFS_GAIN, 32'h00000064);
        rd_chk(OFS_REF, 32'h00000000);
        rd_chk(OFS_STATUS, 32'h00000000);
    endtask : chk_rst

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    //************************************************************
    // watchdog: the whole run needs well under 3000 cycles
    //************************************************************
    initial begin
        repeat (8000) @(posedge i_clk);
        err_total++;
        end_of_test();
    end

    //************************************************************
    // main sequence
    //************************************************************
    initial begin
        {err_total, n_checks, eref} = '0;
        {et, aprev, go, i_arm} = '0;
        {ain_d, ls_d, lc_d} = '0;
        avs = '0;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        chk_rst();
        $display("reset values done");
        // a negative band works by its magnitude
        wr(OFS_BAND, -BAND);
        for (int i = 0; i < NROW; i++) begin
            r = rows[i];
            wr(OFS_GAIN, r.g);
            wr(OFS_OFFSET, r.o);
            wr(OFS_SET_THR, r.s);
            wr(OFS_CLR_THR, r.c);
            wr(OFS_CTRL, r.k);
            scan_in(r.x, r.ls, r.lc, r.a);
            v  = scl(r.x, r.g, r.o);
            sv = (r.k & 1) ? r.ls : r.s;
            cv = (r.k & 2) ? r.lc : r.c;
            if (sv >= cv) begin
                if (v > sv) et = 1'b1;
                else if (v <= cv) et = 1'b0;
            end else begin
                et = (v >= sv) && (v < cv);
            end
            if (r.a != 0 && !aprev) eref = v;
            aprev = r.a[0];
            em = aprev && (v < eref - BAND || v > eref + BAND);
            check(32'(aout), 32'(v));
            check(trig_q, et);
            check(mon_q, em);
            rd_chk(OFS_REF, {16'h0000, 16'(eref)});
            rd_chk(OFS_STATUS, {16'(v), 14'h0000, em, et});
        end
        $display("table rows done");
        wr(OFS_GAIN, 100);
        wr(OFS_CTRL, 0);
        scan_in(600, 0, 0, 1);
        check(trig_q, 1'b1);
        check(mon_q, 1'b1);
        // without a scan nothing moves even when settings change
        wr(OFS_OFFSET, 100);
        repeat (5) @(posedge i_clk);
        check(32'(aout), 32'h00000258);
        check(dly_n >= 4, 1'b1);
        wr(OFS_GAIN, 2000);
        rd_chk(OFS_GAIN, 32'h000003E8);
        wr(OFS_OFFSET, -20000);
        rd_chk(OFS_OFFSET, 32'h0000D8F0);
        wr(OFS_SET_THR, 30000);
        rd_chk(OFS_SET_THR, 32'h00004E20);
        wr(OFS_CLR_THR, -30000);
        rd_chk(OFS_CLR_THR, 32'h0000B1E0);
        wr(OFS_BAND, 30000);
        rd_chk(OFS_BAND, 32'h00004E20);
        wr(OFS_CTRL, 32'h0000000F);
        rd_chk(OFS_CTRL, 32'h0000000F);
        wr(5'h03, 32'h00001234);
        rd_chk(5'h03, 32'h00000000);
        wr(OFS_STATUS, 0);
        rd_chk(OFS_STATUS, 32'h02580003);
        $display("hold and range limits done");
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        chk_rst();
        $display("mid-run reset done");
        end_of_test();
    end

endmodule : tb_top
